// File: core/tmr8_map.svh
// Purpose: offsets, field positions and reset values of the 8-bit timer block
// Assumes: byte-wide register port, one byte per offset
// Notes: definitions only
`ifndef TMR8_MAP_SVH
`define TMR8_MAP_SVH
// ****************************************************************
// register offsets
// ****************************************************************
`define TMR8_OFS_SYNC_CTRL 8'h43
`define TMR8_OFS_IRQ_FLAG  8'h37
`define TMR8_OFS_IRQ_MASK  8'h70
`define TMR8_OFS_PWR       8'h64
`define TMR8_OFS_CTRL_A    8'hB0
`define TMR8_OFS_CTRL_B    8'hB1
`define TMR8_OFS_COUNT     8'hB2
`define TMR8_OFS_CMP_A     8'hB3
`define TMR8_OFS_CMP_B     8'hB4
`define TMR8_OFS_ASYNC     8'hB6
// ****************************************************************
// field positions and pending-write slots
// ****************************************************************
`define TMR8_BIT_HOLD      7
`define TMR8_BIT_APSR      1
`define TMR8_BIT_SPSR      0
`define TMR8_BIT_PWR       6
`define TMR8_BIT_ASEL      5
`define TMR8_P_CNT         0
`define TMR8_P_CMPA        1
`define TMR8_P_CMPB        2
`define TMR8_P_CA          3
`define TMR8_P_CB          4
// ****************************************************************
// reset values and count limits
// ****************************************************************
`define TMR8_RST_BYTE      8'h00
`define TMR8_BOTTOM        8'h00
`define TMR8_MAX           8'hFF
`endif

// File: core/tmr8_pkg.sv
// Purpose: types shared by the 8-bit timer block
// Assumes: constants live in tmr8_map.svh
// Notes: carrier structs and waveform kinds
package tmr8_pkg;
  // cpu register request, one access per cycle
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tmr8_req_t;
  // control register a layout
  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [1:0] rsv;
    logic [1:0] wgm;
  } tmr8_ctrl_a_t;
  // waveform family derived from the mode bits
  typedef enum logic [1:0] {
    TMR8_KIND_PLAIN = 2'h0,
    TMR8_KIND_FAST  = 2'h1,
    TMR8_KIND_PHASE = 2'h3
  } tmr8_kind_t;
endpackage

// File: core/tmr8_timer.sv
// Purpose: 8-bit up/down timer with two compare channels and shared prescaler control
// Assumes: crystal input is a slow pin sampled on i_sys_clk
// Notes: register reads return one cycle after the read strobe
`timescale 1ns/1ns
`default_nettype none
`include "tmr8_map.svh"

// Functional notes
// - writing one to hold mode bit enters synchronization mode
// - in hold mode both prescaler-reset bits keep their written value
// - writing hold mode zero clears both prescaler-reset bits together
// - async prescaler reset bit resets prescaler, then self-clears unless held
// - in crystal mode async reset bit reads one until reset done
// - sync prescaler reset clears shared prescaler, self-clears unless held
// - bottom is 0x00, max 0xFF, top is 0xFF or compare a
// - count and both compare registers are eight bits wide
// - all requests show as flags, each masked individually
// - timer clock is system clock unless async clock select is one
// - clock select zero stops counter; count stays readable and writable
// - cpu count write beats clear, increment or decrement
// - counter clears, counts up or down per waveform mode bits
// - compare equality sets its flag at the next timer clock
// - compare flags clear on service or by writing one
// - compare values double buffered in pwm modes, direct otherwise
// - cpu sees buffer when buffered, active compare otherwise
// - waveform output uses match, mode, output mode, top and bottom
// - power bit written one enables the crystal-capable timer
// - overflow flag set per mode and can raise an interrupt
// - prescaler offers divide 1, 8, 32, 64, 128, 256, 1024
// - normal mode overflow set in the tick the count wraps
module tmr8_timer #(
  parameter int PRE_W = 10
) (
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  // register port
  input  wire tmr8_pkg::tmr8_req_t i_req,
  output logic [7:0]             o_rdata,
  // interrupt service
  input  wire logic [2:0]        i_irq_ack,
  output logic [2:0]             o_irq,
  // crystal oscillator
  input  wire logic              i_crystal_in_pin,
  // compare outputs and pin override enables
  output logic                   o_compare_out_a,
  output logic                   o_compare_out_b,
  output logic                   o_compare_en_a,
  output logic                   o_compare_en_b,
  // shared prescaler of the synchronous timers
  output logic                   o_sync_prescaler_reset,
  output logic [PRE_W-1:0]       o_sync_prescale_count
);
  // ****************************************************************
  // parameter check and helpers
  // ****************************************************************
  if (PRE_W < 10) begin : g_chk
    $error("prescaler needs at least ten bits");
  end

  localparam logic [7:0] OFS [5] = '{`TMR8_OFS_COUNT, `TMR8_OFS_CMP_A, `TMR8_OFS_CMP_B,
                                     `TMR8_OFS_CTRL_A, `TMR8_OFS_CTRL_B};

  // write strobe aimed at one offset
  function automatic logic hit(input tmr8_pkg::tmr8_req_t r, input logic [7:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  // prescaler tap selected by clock select; zero means stopped
  function automatic logic tap(input logic [2:0] cs, input logic [9:0] p);
    logic t;
    t = 1'b0;
    unique case (cs)
      3'h0: t = 1'b0;
      3'h1: t = 1'b1;
      3'h2: t = &p[2:0];
      3'h3: t = &p[4:0];
      3'h4: t = &p[5:0];
      3'h5: t = &p[6:0];
      3'h6: t = &p[7:0];
      3'h7: t = &p[9:0];
    endcase
    return t;
  endfunction

  // next compare output level for one channel
  function automatic logic wave(input logic [1:0] com, input logic cur, input logic m,
                                input logic wrap, input logic dn,
                                input tmr8_pkg::tmr8_kind_t k, input logic t1);
    logic v;
    v = com[0];
    if (com == 2'h0) return cur;
    if (com == 2'h1) return (m && (k == tmr8_pkg::TMR8_KIND_PLAIN || t1)) ? ~cur : cur;
    unique case (k)
      tmr8_pkg::TMR8_KIND_FAST:  return m ? v : (wrap ? ~v : cur);
      tmr8_pkg::TMR8_KIND_PHASE: return m ? (dn ? ~v : v) : cur;
      default:                   return m ? v : cur;
    endcase
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic                   s1_ff, s2_ff, s3_ff;
  logic                   hold_ff, apsr_ff, spsr_ff, pwr_ff, asel_ff;
  logic                   nxt_hold, nxt_apsr, nxt_spsr, nxt_pwr, nxt_asel;
  logic [PRE_W-1:0]       apre_ff, spre_ff, nxt_apre, nxt_spre;
  tmr8_pkg::tmr8_ctrl_a_t ca_ff, nxt_ca;
  logic [3:0]             cb_ff, nxt_cb;
  logic [7:0]             cnt_ff, nxt_cnt;
  logic [7:0]             bufa_ff, bufb_ff, acta_ff, actb_ff;
  logic [7:0]             nxt_bufa, nxt_bufb, nxt_acta, nxt_actb;
  logic                   dn_ff, blk_ff, oca_ff, ocb_ff;
  logic                   nxt_dn, nxt_blk, nxt_oca, nxt_ocb;
  logic [2:0]             flg_ff, msk_ff, nxt_flg, nxt_msk;
  logic [7:0]             pend_ff [5];
  logic [7:0]             nxt_pend [5];
  logic [4:0]             busy_ff, nxt_busy;
  logic [7:0]             rdata_ff, nxt_rdata;

  // ****************************************************************
  // decode
  // ****************************************************************
  logic                   osc_edge, base, tick, pwm, wrap, mat_a, mat_b, tov;
  logic [2:0]             wgm;
  logic [7:0]             topv;
  logic [4:0]             ev;
  logic [7:0]             evd [5];
  tmr8_pkg::tmr8_kind_t   kind;

  // rising crystal edge seen once the second sample is one and the third still zero
  assign osc_edge = s2_ff & ~s3_ff;
  assign base     = asel_ff ? osc_edge : 1'b1;
  // a held async prescaler reset keeps the timer halted
  assign tick     = pwr_ff && base && !apsr_ff && tap(cb_ff[2:0], apre_ff[9:0]);
  assign wgm      = {cb_ff[3], ca_ff.wgm};
  assign pwm      = wgm[0];
  assign kind     = !pwm ? tmr8_pkg::TMR8_KIND_PLAIN :
                    (wgm[1] ? tmr8_pkg::TMR8_KIND_FAST : tmr8_pkg::TMR8_KIND_PHASE);
  assign topv     = (wgm == 3'h2 || wgm[2]) ? acta_ff : `TMR8_MAX;
  assign wrap     = (cnt_ff == topv) && !(kind == tmr8_pkg::TMR8_KIND_PHASE);
  // a count write blocks the match of the next tick
  assign mat_a    = (cnt_ff == acta_ff) && !blk_ff;
  assign mat_b    = (cnt_ff == actb_ff) && !blk_ff;
  // overflow: wrap from max in plain modes, at top in fast, at bottom in phase
  assign tov      = (kind == tmr8_pkg::TMR8_KIND_PHASE) ? (dn_ff && cnt_ff == 8'h01) :
                    (wrap && (pwm || cnt_ff == `TMR8_MAX));

  // write events: direct in system mode, replayed at a crystal edge otherwise
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      ev[i]       = asel_ff ? (busy_ff[i] & osc_edge) : hit(i_req, OFS[i]);
      evd[i]      = asel_ff ? pend_ff[i] : i_req.wdata;
      nxt_pend[i] = hit(i_req, OFS[i]) ? i_req.wdata : pend_ff[i];
      nxt_busy[i] = asel_ff & (hit(i_req, OFS[i]) | (busy_ff[i] & ~osc_edge));
    end
  end

  // ****************************************************************
  // prescaler control
  // ****************************************************************
  always_comb begin
    nxt_hold = hit(i_req, `TMR8_OFS_SYNC_CTRL) ? i_req.wdata[`TMR8_BIT_HOLD] : hold_ff;
    nxt_spsr = spsr_ff & hold_ff;
    // in crystal mode the bit stays up until a crystal edge did the reset
    nxt_apsr = apsr_ff & (hold_ff | (asel_ff & ~osc_edge));
    if (hit(i_req, `TMR8_OFS_SYNC_CTRL)) begin
      nxt_spsr = i_req.wdata[`TMR8_BIT_SPSR];
      nxt_apsr = i_req.wdata[`TMR8_BIT_APSR];
    end
    nxt_spre = spsr_ff ? '0 : spre_ff + 1'b1;
    nxt_apre = apre_ff;
    if (base) begin
      nxt_apre = apsr_ff ? '0 : apre_ff + 1'b1;
    end
    nxt_pwr  = hit(i_req, `TMR8_OFS_PWR) ? i_req.wdata[`TMR8_BIT_PWR] : pwr_ff;
    nxt_asel = hit(i_req, `TMR8_OFS_ASYNC) ? i_req.wdata[`TMR8_BIT_ASEL] : asel_ff;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_ff   <= 1'b0;
      s2_ff   <= 1'b0;
      s3_ff   <= 1'b0;
      hold_ff <= 1'b0;
      apsr_ff <= 1'b0;
      spsr_ff <= 1'b0;
      pwr_ff  <= 1'b0;
      asel_ff <= 1'b0;
      apre_ff <= '0;
      spre_ff <= '0;
      busy_ff <= '0;
      for (int i = 0; i < 5; i++) begin
        pend_ff[i] <= `TMR8_RST_BYTE;
      end
    end else begin
      s1_ff   <= i_crystal_in_pin;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      hold_ff <= nxt_hold;
      apsr_ff <= nxt_apsr;
      spsr_ff <= nxt_spsr;
      pwr_ff  <= nxt_pwr;
      asel_ff <= nxt_asel;
      apre_ff <= nxt_apre;
      spre_ff <= nxt_spre;
      busy_ff <= nxt_busy;
      pend_ff <= nxt_pend;
    end
  end

  // ****************************************************************
  // counter, compare, waveform and flags
  // ****************************************************************
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_dn   = dn_ff;
    nxt_blk  = blk_ff & ~tick;
    nxt_bufa = bufa_ff;
    nxt_bufb = bufb_ff;
    nxt_acta = acta_ff;
    nxt_actb = actb_ff;
    nxt_oca  = oca_ff;
    nxt_ocb  = ocb_ff;
    nxt_ca   = ca_ff;
    nxt_cb   = cb_ff;
    if (tick) begin
      if (kind == tmr8_pkg::TMR8_KIND_PHASE) begin
        if (!dn_ff && cnt_ff == topv) begin
          nxt_dn   = 1'b1;
          nxt_cnt  = cnt_ff - 8'h01;
          nxt_acta = bufa_ff;
          nxt_actb = bufb_ff;
        end else if (dn_ff && cnt_ff == `TMR8_BOTTOM) begin
          nxt_dn  = 1'b0;
          nxt_cnt = cnt_ff + 8'h01;
        end else begin
          nxt_cnt = dn_ff ? cnt_ff - 8'h01 : cnt_ff + 8'h01;
        end
      end else begin
        nxt_dn  = 1'b0;
        nxt_cnt = wrap ? `TMR8_BOTTOM : cnt_ff + 8'h01;
        if (wrap && pwm) begin
          nxt_acta = bufa_ff;
          nxt_actb = bufb_ff;
        end
      end
      nxt_oca = wave(ca_ff.com_a, oca_ff, mat_a, wrap, dn_ff, kind, wgm[2]);
      nxt_ocb = wave(ca_ff.com_b, ocb_ff, mat_b, wrap, dn_ff, kind, 1'b0);
    end
    if (ev[`TMR8_P_CMPA]) begin
      nxt_bufa = evd[`TMR8_P_CMPA];
      if (!pwm) nxt_acta = evd[`TMR8_P_CMPA];
    end
    if (ev[`TMR8_P_CMPB]) begin
      nxt_bufb = evd[`TMR8_P_CMPB];
      if (!pwm) nxt_actb = evd[`TMR8_P_CMPB];
    end
    if (ev[`TMR8_P_CA]) begin
      nxt_ca     = evd[`TMR8_P_CA];
      nxt_ca.rsv = 2'h0;
    end
    if (ev[`TMR8_P_CB]) nxt_cb = evd[`TMR8_P_CB][3:0];
    // cpu write wins over any count action in the same cycle
    if (ev[`TMR8_P_CNT]) begin
      nxt_cnt = evd[`TMR8_P_CNT];
      nxt_blk = 1'b1;
    end
    // set beats clear so an event in the clearing cycle survives
    nxt_flg = ({mat_b, mat_a, tov} & {3{tick}}) |
              (flg_ff & ~(i_irq_ack |
                          (hit(i_req, `TMR8_OFS_IRQ_FLAG) ? i_req.wdata[2:0] : 3'h0)));
    nxt_msk = hit(i_req, `TMR8_OFS_IRQ_MASK) ? i_req.wdata[2:0] : msk_ff;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff  <= `TMR8_RST_BYTE;
      dn_ff   <= 1'b0;
      blk_ff  <= 1'b0;
      bufa_ff <= `TMR8_RST_BYTE;
      bufb_ff <= `TMR8_RST_BYTE;
      acta_ff <= `TMR8_RST_BYTE;
      actb_ff <= `TMR8_RST_BYTE;
      oca_ff  <= 1'b0;
      ocb_ff  <= 1'b0;
      ca_ff   <= `TMR8_RST_BYTE;
      cb_ff   <= 4'h0;
      flg_ff  <= 3'h0;
      msk_ff  <= 3'h0;
    end else begin
      cnt_ff  <= nxt_cnt;
      dn_ff   <= nxt_dn;
      blk_ff  <= nxt_blk;
      bufa_ff <= nxt_bufa;
      bufb_ff <= nxt_bufb;
      acta_ff <= nxt_acta;
      actb_ff <= nxt_actb;
      oca_ff  <= nxt_oca;
      ocb_ff  <= nxt_ocb;
      ca_ff   <= nxt_ca;
      cb_ff   <= nxt_cb;
      flg_ff  <= nxt_flg;
      msk_ff  <= nxt_msk;
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  always_comb begin
    nxt_rdata = rdata_ff;
    if (i_req.rd) begin
      unique case (i_req.addr)
        `TMR8_OFS_SYNC_CTRL: nxt_rdata = {hold_ff, 5'h00, apsr_ff, spsr_ff};
        `TMR8_OFS_IRQ_FLAG:  nxt_rdata = {5'h00, flg_ff};
        `TMR8_OFS_IRQ_MASK:  nxt_rdata = {5'h00, msk_ff};
        `TMR8_OFS_PWR:       nxt_rdata = {1'b0, pwr_ff, 6'h00};
        `TMR8_OFS_CTRL_A:    nxt_rdata = ca_ff;
        `TMR8_OFS_CTRL_B:    nxt_rdata = {4'h0, cb_ff};
        `TMR8_OFS_COUNT:     nxt_rdata = cnt_ff;
        `TMR8_OFS_CMP_A:     nxt_rdata = pwm ? bufa_ff : acta_ff;
        `TMR8_OFS_CMP_B:     nxt_rdata = pwm ? bufb_ff : actb_ff;
        `TMR8_OFS_ASYNC:     nxt_rdata = {2'h0, asel_ff, busy_ff};
        default:             nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // outputs; enables follow the output-mode bits at once
  assign o_rdata                = rdata_ff;
  assign o_irq                  = flg_ff & msk_ff;
  assign o_compare_out_a        = oca_ff;
  assign o_compare_out_b        = ocb_ff;
  assign o_compare_en_a         = |ca_ff.com_a;
  assign o_compare_en_b         = |ca_ff.com_b;
  assign o_sync_prescaler_reset = spsr_ff;
  assign o_sync_prescale_count  = spre_ff;
endmodule
`default_nettype wire

// File: sim/tmr8_properties.sv
// Purpose: port-level properties of the 8-bit timer block
// Assumes: bound into tmr8_timer, one clock domain
// Notes: crystal mode delays control writes, so enable checks skip that mode
`timescale 1ns/1ns
`default_nettype none
`include "tmr8_map.svh"
module tmr8_properties #(
  parameter int PRE_W = 10
) (
  // clock and reset
  input wire logic                i_sys_clk,
  input wire logic                i_rst_n,
  // watched ports
  input wire tmr8_pkg::tmr8_req_t i_req,
  input wire logic [7:0]          o_rdata,
  input wire logic [2:0]          i_irq_ack,
  input wire logic [2:0]          o_irq,
  input wire logic                o_compare_en_a,
  input wire logic                o_compare_en_b,
  input wire logic                o_sync_prescaler_reset,
  input wire logic [PRE_W-1:0]    o_sync_prescale_count
);
  logic      xtal_ff;
  logic      nxt_xtal;
  wire logic wr_sync = i_req.wr && (i_req.addr == `TMR8_OFS_SYNC_CTRL);
  wire logic wr_ca   = i_req.wr && (i_req.addr == `TMR8_OFS_CTRL_A);
  // track the crystal select bit from register writes
  always_comb begin
    nxt_xtal = xtal_ff;
    if (i_req.wr && i_req.addr == `TMR8_OFS_ASYNC) begin
      nxt_xtal = i_req.wdata[`TMR8_BIT_ASEL];
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      xtal_ff <= 1'b0;
    end else begin
      xtal_ff <= nxt_xtal;
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_pulse_wr;
    wr_sync && i_req.wdata[`TMR8_BIT_SPSR] && !i_req.wdata[`TMR8_BIT_HOLD];
  endsequence
  sequence s_hold_wr;
    wr_sync && i_req.wdata[`TMR8_BIT_SPSR] && i_req.wdata[`TMR8_BIT_HOLD];
  endsequence
  property p_enables;
    logic [7:0] d;
    (wr_ca && !xtal_ff, d = i_req.wdata) |=>
      (o_compare_en_a == (d[7:6] != 2'h0)) && (o_compare_en_b == (d[5:4] != 2'h0));
  endproperty
  a_sync_pulse: assert property (s_pulse_wr |=> o_sync_prescaler_reset)
    else $error("sync prescaler reset missing after write");
  a_pulse_ends: assert property (s_pulse_wr ##1 !wr_sync |=> !o_sync_prescaler_reset)
    else $error("sync prescaler reset did not self clear");
  a_hold_keeps: assert property (s_hold_wr ##1 (!wr_sync)[*4] |-> o_sync_prescaler_reset)
    else $error("held prescaler reset dropped");
  a_hold_release: assert property (wr_sync && i_req.wdata == 8'h00 |=> !o_sync_prescaler_reset)
    else $error("prescaler reset not released");
  a_prescale_zero: assert property (o_sync_prescaler_reset |=> o_sync_prescale_count == '0)
    else $error("shared prescaler not cleared");
  a_mask_zero: assert property (i_req.wr && i_req.addr == `TMR8_OFS_IRQ_MASK
    && i_req.wdata[2:0] == 3'h0 |=> o_irq == 3'h0)
    else $error("masked request still raised");
  a_ack_clear: assert property (i_irq_ack[1] && o_irq[1] |=> !o_irq[1])
    else $error("serviced compare flag not cleared");
  a_enable_follow: assert property (p_enables)
    else $error("pin override enable wrong");
  a_rdata_hold: assert property (!i_req.rd |=> $stable(o_rdata))
    else $error("read data moved without a read");
  a_reserved_zero: assert property (i_req.rd && i_req.addr == `TMR8_OFS_SYNC_CTRL
    |=> o_rdata[6:2] == 5'h00)
    else $error("reserved control bits read nonzero");
endmodule
bind tmr8_timer tmr8_properties #(.PRE_W(PRE_W)) u_props (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_req(i_req), .o_rdata(o_rdata),
  .i_irq_ack(i_irq_ack), .o_irq(o_irq), .o_compare_en_a(o_compare_en_a),
  .o_compare_en_b(o_compare_en_b), .o_sync_prescaler_reset(o_sync_prescaler_reset),
  .o_sync_prescale_count(o_sync_prescale_count)
);
`default_nettype wire

// File: sim/tb_async_timer8_with_prescaler_sync.sv
// Purpose: self-checking bench for the 8-bit timer block
// Assumes: reads answer one cycle after the strobe
// Notes: tick counts carry one tick of prescaler phase slack, hence masked compares
`timescale 1ns/1ns
`default_nettype none
`include "tmr8_map.svh"
module tb_async_timer8_with_prescaler_sync;
  localparam int PRE_W = 10;
  logic                sys_clk;
  logic                rst_n;
  logic                xtal;
  logic                xtal_run;
  logic                rd_seen;
  tmr8_pkg::tmr8_req_t req;
  logic [7:0]          rdata;
  logic [2:0]          ack;
  logic [2:0]          irq;
  logic [15:0]         note;
  logic [15:0]         exp_q[$];
  logic [31:0]         lfsr_st;
  logic [7:0]          d;
  int                  bad_count;
  int                  checked;
  int                  xdiv;
  logic [7:0]          ofs [11] = '{`TMR8_OFS_SYNC_CTRL, `TMR8_OFS_IRQ_FLAG, `TMR8_OFS_IRQ_MASK,
    `TMR8_OFS_PWR, `TMR8_OFS_CTRL_A, `TMR8_OFS_CTRL_B, `TMR8_OFS_COUNT, `TMR8_OFS_CMP_A,
    `TMR8_OFS_CMP_B, `TMR8_OFS_ASYNC, 8'h00};
  int                  divs [7] = '{1, 8, 32, 64, 128, 256, 1024};

  tmr8_timer #(.PRE_W(PRE_W)) u_dut (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_req(req), .o_rdata(rdata),
    .i_irq_ack(ack), .o_irq(irq), .i_crystal_in_pin(xtal),
    .o_compare_out_a(), .o_compare_out_b(), .o_compare_en_a(), .o_compare_en_b(),
    .o_sync_prescaler_reset(), .o_sync_prescale_count()
  );
  // 50 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk);
    checked++;
    if ((got & msk) !== (exp & msk)) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    req <= '{a, v, 1'b1, 1'b0};
    @(posedge sys_clk);
    req <= '0;
  endtask
  // reads leave a note; the monitor below checks it when data lands
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge sys_clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    exp_q.push_back({m, e});
    @(posedge sys_clk);
    req <= '0;
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // read-data monitor, one cycle behind the strobe
  always @(posedge sys_clk) begin
    if (rd_seen === 1'b1 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      cmp(rdata, note[7:0], note[15:8]);
    end
    rd_seen <= req.rd;
  end
  // crystal pin at a tenth of the system rate, can be frozen
  always @(posedge sys_clk) begin
    xdiv <= (xdiv == 4) ? 0 : xdiv + 1;
    if (xtal_run && xdiv == 4) begin
      xtal <= ~xtal;
    end
  end
  // watchdog sized well past the longest prescaler run
  initial begin
    #(20 * 80000);
    bad_count++;
    print_verdict();
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    req = '0;
    ack = 3'h0;
    xtal = 1'b0;
    xtal_run = 1'b1;
    rst_n = 1'b0;
    rd_seen = 1'b0;
    xdiv = 0;
    bad_count = 0;
    checked = 0;
    lfsr_st = 32'h8BCF5EFC;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (ofs[i]) rd(ofs[i], 8'h00, 8'hFF);
    wr(`TMR8_OFS_CTRL_B, 8'h01);
    idle(20);
    rd(`TMR8_OFS_COUNT, 8'h00, 8'hFF);
    wr(`TMR8_OFS_PWR, 8'h40);
    rd(`TMR8_OFS_PWR, 8'h40, 8'hFF);
    wr(`TMR8_OFS_CTRL_B, 8'h00);
    repeat (4) begin
      lfsr_st = lfsr_next(lfsr_st);
      wr(`TMR8_OFS_COUNT, lfsr_st[7:0]);
      idle(5);
      rd(`TMR8_OFS_COUNT, lfsr_st[7:0], 8'hFF);
    end
    foreach (divs[k]) begin
      wr(`TMR8_OFS_COUNT, 8'h00);
      wr(`TMR8_OFS_SYNC_CTRL, 8'h02);
      rd(`TMR8_OFS_SYNC_CTRL, 8'h00, 8'hFF);
      wr(`TMR8_OFS_CTRL_B, 8'(k + 1));
      idle(20 * divs[k]);
      wr(`TMR8_OFS_CTRL_B, 8'h00);
      rd(`TMR8_OFS_COUNT, 8'h10, 8'hF8);
    end
    wr(`TMR8_OFS_COUNT, 8'hF8);
    wr(`TMR8_OFS_CMP_A, 8'hFA);
    wr(`TMR8_OFS_CMP_B, 8'h00);
    wr(`TMR8_OFS_IRQ_MASK, 8'h07);
    wr(`TMR8_OFS_CTRL_B, 8'h01);
    idle(8);
    wr(`TMR8_OFS_CTRL_B, 8'h00);
    rd(`TMR8_OFS_IRQ_FLAG, 8'h07, 8'hFF);
    rd(`TMR8_OFS_COUNT, 8'h00, 8'hF8);
    // look at the level between edges, once the flops have settled
    @(negedge sys_clk);
    cmp({5'h00, irq}, 8'h07, 8'hFF);
    wr(`TMR8_OFS_IRQ_MASK, 8'h02);
    @(negedge sys_clk);
    cmp({5'h00, irq}, 8'h02, 8'hFF);
    ack <= 3'h2;
    @(posedge sys_clk);
    ack <= 3'h0;
    rd(`TMR8_OFS_IRQ_FLAG, 8'h05, 8'hFF);
    wr(`TMR8_OFS_IRQ_FLAG, 8'h05);
    rd(`TMR8_OFS_IRQ_FLAG, 8'h00, 8'hFF);
    wr(`TMR8_OFS_IRQ_MASK, 8'h00);
    wr(`TMR8_OFS_CTRL_B, 8'h01);
    wr(`TMR8_OFS_COUNT, 8'h80);
    wr(`TMR8_OFS_CTRL_B, 8'h00);
    rd(`TMR8_OFS_COUNT, 8'h80, 8'hF8);
    wr(`TMR8_OFS_CTRL_A, 8'h02);
    // start below top, else the count runs the long way round first
    wr(`TMR8_OFS_COUNT, 8'h00);
    wr(`TMR8_OFS_CMP_A, 8'h03);
    wr(`TMR8_OFS_CTRL_B, 8'h01);
    idle(37);
    wr(`TMR8_OFS_CTRL_B, 8'h00);
    rd(`TMR8_OFS_COUNT, 8'h00, 8'hFC);
    wr(`TMR8_OFS_COUNT, 8'h00);
    wr(`TMR8_OFS_SYNC_CTRL, 8'h83);
    wr(`TMR8_OFS_CTRL_B, 8'h01);
    idle(20);
    rd(`TMR8_OFS_SYNC_CTRL, 8'h83, 8'hFF);
    rd(`TMR8_OFS_COUNT, 8'h00, 8'hFF);
    wr(`TMR8_OFS_SYNC_CTRL, 8'h00);
    rd(`TMR8_OFS_SYNC_CTRL, 8'h00, 8'hFF);
    wr(`TMR8_OFS_SYNC_CTRL, 8'h01);
    rd(`TMR8_OFS_SYNC_CTRL, 8'h00, 8'hFF);
    wr(`TMR8_OFS_CTRL_B, 8'h00);
    for (int w = 1; w < 4; w += 2) begin
      lfsr_st = lfsr_next(lfsr_st);
      d = {lfsr_st[7:4], 2'h0, 2'(w)};
      wr(`TMR8_OFS_CTRL_A, d);
      rd(`TMR8_OFS_CTRL_A, d, 8'hF3);
      wr(`TMR8_OFS_CMP_A, lfsr_st[15:8]);
      rd(`TMR8_OFS_CMP_A, lfsr_st[15:8], 8'hFF);
    end
    wr(`TMR8_OFS_CTRL_A, 8'h00);
    wr(`TMR8_OFS_ASYNC, 8'h20);
    wr(`TMR8_OFS_COUNT, 8'h00);
    wr(`TMR8_OFS_CTRL_B, 8'h01);
    idle(200);
    wr(`TMR8_OFS_CTRL_B, 8'h00);
    idle(20);
    rd(`TMR8_OFS_COUNT, 8'h10, 8'hF8);
    xtal_run <= 1'b0;
    idle(6);
    wr(`TMR8_OFS_SYNC_CTRL, 8'h02);
    idle(3);
    rd(`TMR8_OFS_SYNC_CTRL, 8'h02, 8'h02);
    xtal_run <= 1'b1;
    idle(30);
    rd(`TMR8_OFS_SYNC_CTRL, 8'h00, 8'hFF);
    idle(4);
    print_verdict();
  end
endmodule
`default_nettype wire
